// ---- hdl/clut_consts.vh ----
`ifndef CLUT_CONSTS_VH
`define CLUT_CONSTS_VH

// table and comparator counts
`define CLUT_NUM_TABLES 4
`define CLUT_NUM_COMPS 4
`define CLUT_IDX_W 2

// function-select control word codes
`define CLUT_FN_W 4
`define CLUT_FN_LOW 4'h0
`define CLUT_FN_AND 4'h1
`define CLUT_FN_A_ANDN_B 4'h2
`define CLUT_FN_A 4'h3
`define CLUT_FN_NA_AND_B 4'h4
`define CLUT_FN_B 4'h5
`define CLUT_FN_XOR 4'h6
`define CLUT_FN_OR 4'h7
`define CLUT_FN_NOR 4'h8
`define CLUT_FN_XNOR 4'h9
`define CLUT_FN_NOT_B 4'hA
`define CLUT_FN_A_ORN_B 4'hB
`define CLUT_FN_NOT_A 4'hC
`define CLUT_FN_NA_OR_B 4'hD
`define CLUT_FN_NAND 4'hE
`define CLUT_FN_HIGH 4'hF

// table configuration word layout: {sel_b, sel_a, function}
`define CLUT_CFG_W 8
`define CLUT_CFG_FN_LSB 0
`define CLUT_CFG_FN_MSB 3
`define CLUT_CFG_SELA_LSB 4
`define CLUT_CFG_SELA_MSB 5
`define CLUT_CFG_SELB_LSB 6
`define CLUT_CFG_SELB_MSB 7
`define CLUT_CFG_RESET 8'h00

// routing fabric: four destination classes of four channels each
`define CLUT_NUM_DEST 16
`define CLUT_DEST_PER_CLASS 4
`define CLUT_DEST_IDX_W 4
`define CLUT_ROUTE_W 3
`define CLUT_ROUTE_EN_BIT 2
`define CLUT_ROUTE_SRC_LSB 0
`define CLUT_ROUTE_SRC_MSB 1
`define CLUT_ROUTE_RESET 3'h0
`define CLUT_DEST_PDB_BASE 0
`define CLUT_DEST_DMA_BASE 4
`define CLUT_DEST_IO_BASE 8
`define CLUT_DEST_IRQ_BASE 12

`endif

// ---- hdl/clut_sync.v ----
`timescale 1ns/1ps
// two-stage synchroniser for the asynchronous comparator levels
module clut_sync
(
  // clock, reset, enable
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  // asynchronous levels in, synchronised levels out
  input wire [3:0] async_in,
  output reg [3:0] sync_out
);

  reg [3:0] meta;

  // first stage feeds only the second stage, never any logic
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      meta <= 4'h0;
      sync_out <= 4'h0;
    end
    else if (clk_en)
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // clut_sync

// ---- hdl/clut_table.v ----
`timescale 1ns/1ps
`include "clut_consts.vh"
// one two-input lookup table, purely combinational
module clut_table
(
  // function select word
  input wire [3:0] fn_word,
  // table inputs
  input wire in_a,
  input wire in_b,
  // table result
  output wire lut_out
);

  // decode the sixteen functions; written out so each code is visible
  function fn_eval;
    input [3:0] word;
    input a;
    input b;
    begin
      case (word)
        `CLUT_FN_LOW: fn_eval = 1'b0;
        `CLUT_FN_AND: fn_eval = a & b;
        `CLUT_FN_A_ANDN_B: fn_eval = a & ~b;
        `CLUT_FN_A: fn_eval = a;
        `CLUT_FN_NA_AND_B: fn_eval = ~a & b;
        `CLUT_FN_B: fn_eval = b;
        `CLUT_FN_XOR: fn_eval = a ^ b;
        `CLUT_FN_OR: fn_eval = a | b;
        `CLUT_FN_NOR: fn_eval = ~(a | b);
        `CLUT_FN_XNOR: fn_eval = ~(a ^ b);
        `CLUT_FN_NOT_B: fn_eval = ~b;
        `CLUT_FN_A_ORN_B: fn_eval = a | ~b;
        `CLUT_FN_NOT_A: fn_eval = ~a;
        `CLUT_FN_NA_OR_B: fn_eval = ~a | b;
        `CLUT_FN_NAND: fn_eval = ~(a & b);
        `CLUT_FN_HIGH: fn_eval = 1'b1;
        default: fn_eval = 1'b0;
      endcase
    end
  endfunction

  // no clock or pipeline stage inside the table
  assign lut_out = fn_eval(fn_word, in_a, in_b);

endmodule // clut_table

// ---- hdl/clut_top.v ----
`timescale 1ns/1ps
`include "clut_consts.vh"
// Functional notes
// - There are four lookup tables, each with its own function-select word.
// - Each table takes two one-bit inputs A and B and gives one one-bit output.
// - Each table input picks any comparator, so one or two comparators can drive it.
// - Every table output goes to the digital routing fabric.
// - The fabric can carry any table result to digital blocks, DMA, I/O and interrupts.
// - A written and stored control word sets the function each table applies.
// - Word 0011b passes A through and 1100b gives NOT A.
// - Word 0000b gives constant low and 1111b gives constant high.
// - Words 0001b, 0010b, 0100b give A AND B, A AND NOT B, NOT A AND B.
// - Word 0101b passes B through and 1010b gives NOT B.
// - Word 0110b gives A XOR B and 1001b gives A XNOR B.
// - Words 0111b, 1000b, 1110b give A OR B, A NOR B, A NAND B.
// - Word 1011b gives A OR NOT B and 1101b gives NOT A OR B.
// - Each comparator output can be routed to either table input to reach the fabric.
module clut_top
(
  // clock, reset, enable
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  // analog comparator outputs, asynchronous
  input wire [3:0] comp_in,
  // table configuration write port
  input wire cfg_wr,
  input wire [1:0] cfg_table,
  input wire [7:0] cfg_wdata,
  // routing configuration write port
  input wire route_wr,
  input wire [3:0] route_dest,
  input wire [2:0] route_wdata,
  // configuration readback
  input wire [1:0] rd_table,
  output reg [7:0] rd_cfg,
  // raw table results to the routing fabric
  output wire [3:0] lut_out,
  // routed destinations
  output reg [3:0] programmable_digital_block_in,
  output reg [3:0] dma_req,
  output reg [3:0] io_out,
  output reg [3:0] irq_req
);

  // configuration word of a table: [3:0] function, [5:4] comparator on A, [7:6] on B
  // both selects may name one comparator, and the table then sees A equal to B
  // route word of a destination: [2] enable, [1:0] table that drives it
  // destinations 0-3 feed digital blocks, 4-7 dma, 8-11 i/o, 12-15 interrupt requests
  // writes are level strobes: a strobe held high rewrites the word on each enabled edge
  // a table write and a route write may land on one edge; they touch separate words
  // reset clears every word: function 0000 holds each table low and every route is off
  // a comparator edge reaches lut_out after two enabled edges, routed outputs after three
  // routed outputs and the readback lag the stored words by one enabled edge
  // clk_en low freezes every flop unless reset is high, so lut_out and all outputs hold their levels

  // synchronised comparator levels; nothing else reads comp_in
  wire [3:0] comp_sync;
  // table inputs after comparator selection
  wire [3:0] lut_a;
  wire [3:0] lut_b;
  // stored control words, one per table, and one route word per destination
  reg [7:0] table_cfg [0:3];
  reg [2:0] route_cfg [0:15];
  // one-hot write enables decoded from the two write ports
  reg [3:0] table_we;
  reg [15:0] route_we;
  // next values of the registered outputs
  reg [3:0] next_programmable_digital_block_in;
  reg [3:0] next_dma_req;
  reg [3:0] next_io_out;
  reg [3:0] next_irq_req;
  reg [7:0] next_rd_cfg;
  // loop indices, one per process so that each has a single driver
  integer idx_tab;
  integer idx_dst;
  integer ch_pdb;
  integer ch_dma;
  integer ch_io;
  integer ch_irq;

  // pick one bit of four by index
  function pick4;
    input [3:0] vec;
    input [1:0] idx;
    begin
      pick4 = vec[idx];
    end
  endfunction

  // function-select field of a table configuration word
  function [3:0] cfg_fn;
    input [7:0] cfg;
    begin
      cfg_fn = cfg[`CLUT_CFG_FN_MSB:`CLUT_CFG_FN_LSB];
    end
  endfunction

  // comparator index feeding input A
  function [1:0] cfg_sel_a;
    input [7:0] cfg;
    begin
      cfg_sel_a = cfg[`CLUT_CFG_SELA_MSB:`CLUT_CFG_SELA_LSB];
    end
  endfunction

  // comparator index feeding input B
  function [1:0] cfg_sel_b;
    input [7:0] cfg;
    begin
      cfg_sel_b = cfg[`CLUT_CFG_SELB_MSB:`CLUT_CFG_SELB_LSB];
    end
  endfunction

  // one-hot table decode; all zero while no write is pending
  function [3:0] dec_table;
    input [1:0] idx;
    input en;
    begin
      dec_table = 4'h0;
      dec_table[idx] = en;
    end
  endfunction

  // one-hot destination decode; all zero while no write is pending
  function [15:0] dec_dest;
    input [3:0] idx;
    input en;
    begin
      dec_dest = 16'h0000;
      dec_dest[idx] = en;
    end
  endfunction

  // route a table result to a destination when that channel is enabled
  function route_bit;
    input [2:0] cfg;
    input [3:0] res;
    begin
      route_bit = cfg[`CLUT_ROUTE_EN_BIT] &
        pick4(res, cfg[`CLUT_ROUTE_SRC_MSB:`CLUT_ROUTE_SRC_LSB]);
    end
  endfunction

  // comparators are asynchronous to clk_sys, so two flops before any use
  clut_sync u_sync
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(comp_in),
    .sync_out(comp_sync)
  );

  // write decode; clk_en gates the store, so a write on a frozen edge is dropped
  always @*
  begin
    table_we = dec_table(cfg_table, cfg_wr);
    route_we = dec_dest(route_dest, route_wr);
  end

  // stored table words; a write lands on the next enabled edge
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (idx_tab = 0; idx_tab < `CLUT_NUM_TABLES; idx_tab = idx_tab + 1)
        table_cfg[idx_tab] <= `CLUT_CFG_RESET;
    end
    else if (clk_en)
    begin
      for (idx_tab = 0; idx_tab < `CLUT_NUM_TABLES; idx_tab = idx_tab + 1)
      begin
        if (table_we[idx_tab])
          table_cfg[idx_tab] <= cfg_wdata;
      end
    end
  end

  // stored route words; a disabled route drives its destination low
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (idx_dst = 0; idx_dst < `CLUT_NUM_DEST; idx_dst = idx_dst + 1)
        route_cfg[idx_dst] <= `CLUT_ROUTE_RESET;
    end
    else if (clk_en)
    begin
      for (idx_dst = 0; idx_dst < `CLUT_NUM_DEST; idx_dst = idx_dst + 1)
      begin
        if (route_we[idx_dst])
          route_cfg[idx_dst] <= route_wdata;
      end
    end
  end

  // four independent tables, each input selecting any comparator
  genvar g;
  generate
    for (g = 0; g < `CLUT_NUM_TABLES; g = g + 1)
    begin : g_table
      // a select only moves a level between comparators; the sync path stays in front
      assign lut_a[g] = pick4(comp_sync, cfg_sel_a(table_cfg[g]));
      assign lut_b[g] = pick4(comp_sync, cfg_sel_b(table_cfg[g]));
      clut_table u_table
      (
        .fn_word(cfg_fn(table_cfg[g])),
        .in_a(lut_a[g]),
        .in_b(lut_b[g]),
        .lut_out(lut_out[g])
      );
    end
  endgenerate

  // digital block channels
  always @*
  begin
    next_programmable_digital_block_in = 4'h0;
    for (ch_pdb = 0; ch_pdb < `CLUT_DEST_PER_CLASS; ch_pdb = ch_pdb + 1)
    begin
      next_programmable_digital_block_in[ch_pdb] =
        route_bit(route_cfg[`CLUT_DEST_PDB_BASE + ch_pdb], lut_out);
    end
  end

  // dma request channels
  always @*
  begin
    next_dma_req = 4'h0;
    for (ch_dma = 0; ch_dma < `CLUT_DEST_PER_CLASS; ch_dma = ch_dma + 1)
    begin
      next_dma_req[ch_dma] =
        route_bit(route_cfg[`CLUT_DEST_DMA_BASE + ch_dma], lut_out);
    end
  end

  // i/o channels
  always @*
  begin
    next_io_out = 4'h0;
    for (ch_io = 0; ch_io < `CLUT_DEST_PER_CLASS; ch_io = ch_io + 1)
    begin
      next_io_out[ch_io] =
        route_bit(route_cfg[`CLUT_DEST_IO_BASE + ch_io], lut_out);
    end
  end

  // interrupt request channels
  always @*
  begin
    next_irq_req = 4'h0;
    for (ch_irq = 0; ch_irq < `CLUT_DEST_PER_CLASS; ch_irq = ch_irq + 1)
    begin
      next_irq_req[ch_irq] =
        route_bit(route_cfg[`CLUT_DEST_IRQ_BASE + ch_irq], lut_out);
    end
  end

  // readback copy of the selected table word
  always @*
  begin
    next_rd_cfg = table_cfg[rd_table];
  end

  // digital block outputs registered so destinations see glitch-free levels
  always @(posedge clk_sys)
  begin
    if (reset)
      programmable_digital_block_in <= 4'h0;
    else if (clk_en)
      programmable_digital_block_in <= next_programmable_digital_block_in;
  end

  // dma requests are levels; the controller sees no pulse stretching here
  always @(posedge clk_sys)
  begin
    if (reset)
      dma_req <= 4'h0;
    else if (clk_en)
      dma_req <= next_dma_req;
  end

  // i/o levels, registered so a table glitch never reaches a pin
  always @(posedge clk_sys)
  begin
    if (reset)
      io_out <= 4'h0;
    else if (clk_en)
      io_out <= next_io_out;
  end

  // interrupt requests are levels; any edge detection sits in the controller
  always @(posedge clk_sys)
  begin
    if (reset)
      irq_req <= 4'h0;
    else if (clk_en)
      irq_req <= next_irq_req;
  end

  // readback register, one enabled edge behind the stored word
  always @(posedge clk_sys)
  begin
    if (reset)
      rd_cfg <= `CLUT_CFG_RESET;
    else if (clk_en)
      rd_cfg <= next_rd_cfg;
  end

endmodule // clut_top

// ---- sim/clut_asserts.sv ----
`timescale 1ns/1ps
module clut_asserts
(
  // inputs
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  input wire [3:0] comp_in,
  input wire cfg_wr,
  input wire [1:0] cfg_table,
  input wire [7:0] cfg_wdata,
  input wire route_wr,
  input wire [3:0] route_dest,
  input wire [2:0] route_wdata,
  input wire [1:0] rd_table,
  // outputs
  input wire [7:0] rd_cfg,
  input wire [3:0] lut_out,
  input wire [3:0] programmable_digital_block_in,
  input wire [3:0] dma_req,
  input wire [3:0] io_out,
  input wire [3:0] irq_req
);
  logic ok = 1'b0;
  logic [3:0] c1, c2, l_d;
  logic [1:0] t_d;
  logic [7:0] w_d;
  logic [5:0] r_d, r_dd;
  wire [15:0] dst = {irq_req, io_out, dma_req, programmable_digital_block_in};
  // delayed copies; c2 lines up with the two-flop comparator path
  always @(posedge clk_sys)
    {ok, c1, c2, l_d, t_d, w_d, r_d, r_dd} <= {clk_en && !reset, comp_in, c1, lut_out,
      cfg_table, cfg_wdata, route_dest, route_wdata[1:0], r_d};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_FN: assert property (cfg_wr && clk_en && ok |=>
    lut_out[t_d] == w_d[{~c2[w_d[5:4]], ~c2[w_d[7:6]]}]) else $error("fn");
  AST_LOW: assert property (cfg_wr && clk_en && cfg_wdata[3:0] == 4'h0 |=> !lut_out[t_d])
    else $error("low");
  AST_HIGH: assert property (cfg_wr && clk_en && cfg_wdata[3:0] == 4'hF |=> lut_out[t_d])
    else $error("high");
  AST_SAME: assert property (cfg_wr && clk_en && cfg_wdata == 8'hF6 |=> !lut_out[t_d])
    else $error("same");
  AST_RESET: assert property (disable iff (1'b0) reset |=> {lut_out, dst, rd_cfg} == 28'h0)
    else $error("reset");
  AST_RD: assert property (cfg_wr && clk_en ##1 clk_en && rd_table == t_d |=>
    rd_cfg == $past(cfg_wdata, 2)) else $error("rd");
  AST_ROUTE: assert property (route_wr && clk_en && route_wdata[2] ##1 clk_en |=>
    dst[r_dd[5:2]] == l_d[r_dd[1:0]]) else $error("route");
  AST_FREEZE: assert property (!clk_en |=> $stable(lut_out) && $stable(dst))
    else $error("hold");
endmodule // clut_asserts

// ---- sim/clut_comp_model.sv ----
`timescale 1ns/1ps
// comparator bank; levels settle off the clock edge, as an analog output would
module clut_comp_model
(
  // wanted levels in, comparator outputs out
  input wire [3:0] level_req,
  output wire [3:0] comp_out
);
  assign #2 comp_out = level_req;
endmodule // clut_comp_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b, m) \
  num_checks++; \
  if ((a) !== (b)) err(m);
module tb_top;
  // block inputs, all set at time zero
  logic clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1, cfg_wr = 1'b0, route_wr = 1'b0;
  logic [1:0] cfg_table = 2'h0, rd_table = 2'h0;
  logic [7:0] cfg_wdata = 8'h00;
  logic [3:0] route_dest = 4'h0, lvl = 4'h0;
  logic [2:0] route_wdata = 3'h0;
  wire [3:0] comp_in, lut_out, programmable_digital_block_in, dma_req, io_out, irq_req;
  wire [7:0] rd_cfg;
  wire [15:0] dst = {irq_req, io_out, dma_req, programmable_digital_block_in};
  int num_errors = 0, num_checks = 0;
  // system clock
  always #4 clk_sys = ~clk_sys;
  clut_comp_model u_cmp (.level_req(lvl), .comp_out(comp_in));
  clut_top u_dut (.*);
  task automatic err(input string m);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  // one-cycle strobe on the table or routing port, then n idle cycles
  task automatic wr(input logic cw, input logic [3:0] a, input logic [7:0] d, input int n);
    {cfg_table, cfg_wdata, route_dest, route_wdata} = {a[1:0], d, a, d[2:0]};
    {cfg_wr, route_wr} = {cw, !cw};
    @(negedge clk_sys);
    {cfg_wr, route_wr} = 2'h0;
    repeat (n) @(negedge clk_sys);
  endtask
  // every word over every input pair, A and B on different comparators
  task automatic t_funcs();
    for (int w = 0; w < 16; w++)
      for (int i = 0; i < 4; i++)
      begin
        lvl = ({3'h0, i[0]} << w[1:0]) | ({3'h0, i[1]} << ~w[1:0]);
        wr(1'b1, 4'(w[1:0]), {~w[1:0], w[1:0], w[3:0]}, 3);
        `CHK(lut_out[w[1:0]], w[{~i[0], ~i[1]}], "fn")
      end
  endtask
  // one destination at a time, only table h high
  task automatic t_route();
    for (int h = 0; h < 4; h++)
    begin
      for (int t = 0; t < 4; t++)
        wr(1'b1, 4'(t), (t == h) ? 8'h0F : 8'h00, 1);
      for (int d = 0; d < 16; d++)
      begin
        wr(1'b0, 4'(d), {5'h00, 1'b1, d[3:2]}, 2);
        `CHK(dst, (d[3:2] == h) ? 16'h0001 << d : 16'h0000, "route")
        wr(1'b0, 4'(d), 8'h00, 1);
      end
    end
  endtask
  // readback, one comparator on both inputs, a write while disabled
  task automatic t_hold();
    lvl = 4'h9;
    rd_table = 2'h1;
    wr(1'b1, 4'h2, 8'hF6, 1);
    wr(1'b1, 4'h1, 8'h99, 2);
    `CHK({rd_cfg, lut_out[2:1]}, {8'h99, 2'h1}, "rd")
    clk_en = 1'b0;
    wr(1'b1, 4'h1, 8'h00, 2);
    clk_en = 1'b1;
    wr(1'b0, 4'h0, 8'h00, 1);
    `CHK({rd_cfg, lut_out[1]}, {8'h99, 1'b1}, "hold")
  endtask
  task automatic results();
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // reset for five cycles, then the scenarios
  initial
  begin
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    `CHK({rd_cfg, lut_out, dst}, 28'h0, "reset")
    t_funcs();
    t_route();
    t_hold();
    results();
  end
endmodule // tb_top
bind clut_top clut_asserts u_chk (.*);
